// file: dv/rtc_serial_slave_port_tb.sv
// Self-checking testbench for the two-wire serial slave port.
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_slave_port_tb
    import rtc_serial_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int         REC_T  = 60;
    localparam logic [7:0] ADDR_W = {SLAVE_ADDR, 1'b0};
    localparam logic [7:0] ADDR_R = {SLAVE_ADDR, 1'b1};

    logic       ref_clk    = 1'b0;
    logic       arst_n     = 1'b0;
    logic       power_fail = 1'b0;
    logic       scl, sda_low, sda_out, sda_oe, wr_en, copy_hold;
    wire logic  sda_wire;
    logic [2:0] rd_addr, wr_addr;
    logic [7:0] rd_data, wr_data;
    logic [7:0] mem [8];
    int         bad_count   = 0;
    int         check_count = 0;
    int         wr_count    = 0;

    always #12.5 ref_clk = ~ref_clk;
    // Pulled-up open-drain wire
    assign sda_wire = ~(sda_oe | sda_low);
    assign rd_data  = mem[rd_addr];

    always @(posedge ref_clk) begin
        if (wr_en === 1'b1) begin
            mem[wr_addr] <= wr_data;
            wr_count     <= wr_count + 1;
        end
    end

    rtc_serial_slave_port #(.REC_COUNT(REC_T)) uut (
        .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .power_fail(power_fail),
        .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .copy_hold(copy_hold)
    );

    two_wire_master_model m (
        .ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low)
    );

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_reset();
        chk("sda_oe", 8'h00, sda_oe);
        chk("sda_out", 8'h00, sda_out);
        chk("rd_addr", 8'h00, rd_addr);
        chk("copy_hold", 8'h00, copy_hold);
        chk("wr_en", 8'h00, wr_en);
    endtask

    // Write across the calibration slot so the pointer wraps
    task automatic sc_write();
        logic a;
        m.start_cond();
        m.write_byte(ADDR_W, a);
        chk("addr ack", 8'h01, a);
        m.write_byte(8'h06, a);
        chk("word ack", 8'h01, a);
        chk("pointer load", 8'h06, rd_addr);
        chk("hold clock loc", 8'h01, copy_hold);
        m.write_byte(8'ha5, a);
        chk("hold cal loc", 8'h00, copy_hold);
        m.write_byte(8'h5a, a);
        m.write_byte(8'h3c, a);
        chk("data ack", 8'h01, a);
        chk("hold after wrap", 8'h01, copy_hold);
        m.stop_cond();
        chk("hold after stop", 8'h00, copy_hold);
        chk("mem 6", 8'ha5, mem[6]);
        chk("mem 7", 8'h5a, mem[7]);
        chk("mem 0", 8'h3c, mem[0]);
        chk("write count", 8'h03, wr_count[7:0]);
        chk("pointer end", 8'h01, rd_addr);
    endtask

    task automatic sc_read();
        logic       a;
        logic [7:0] d;
        m.start_cond();
        m.write_byte(ADDR_W, a);
        m.write_byte(8'h05, a);
        m.start_cond();
        m.write_byte(ADDR_R, a);
        chk("read addr ack", 8'h01, a);
        chk("hold in read", 8'h01, copy_hold);
        m.read_byte(1'b0, d);
        chk("read 5", 8'h15, d);
        m.read_byte(1'b0, d);
        chk("read 6", 8'ha5, d);
        m.read_byte(1'b1, d);
        chk("read 7", 8'h5a, d);
        m.wait_cyc(4);
        // Next byte starts with a zero, so a missed release pulls SDA low
        chk("release after nack", 8'h00, sda_oe);
        m.stop_cond();
        m.start_cond();
        m.write_byte(ADDR_R, a);
        m.read_byte(1'b1, d);
        chk("current pointer read", 8'h3c, d);
        m.stop_cond();
    endtask

    task automatic sc_foreign();
        logic a;
        m.start_cond();
        m.write_byte(8'ha0, a);
        chk("foreign nack", 8'h00, a);
        m.write_byte(8'h02, a);
        m.write_byte(8'h77, a);
        chk("foreign data nack", 8'h00, a);
        chk("foreign writes", 8'h03, wr_count[7:0]);
        chk("foreign hold", 8'h00, copy_hold);
        chk("foreign pointer", 8'h01, rd_addr);
        m.stop_cond();
    endtask

    // Supply loss in mid read, ignored traffic, then the recovery window
    task automatic sc_power();
        logic a;
        m.start_cond();
        m.write_byte(ADDR_R, a);
        chk("driving bit", 8'h01, sda_oe);
        chk("sda_out low", 8'h00, sda_out);
        power_fail <= 1'b1;
        m.wait_cyc(6);
        chk("abort release", 8'h00, sda_oe);
        chk("pointer cleared", 8'h00, rd_addr);
        m.stop_cond();
        m.start_cond();
        m.write_byte(ADDR_W, a);
        chk("ignored addr", 8'h00, a);
        m.write_byte(8'h02, a);
        m.write_byte(8'h99, a);
        m.stop_cond();
        chk("no write on fail", 8'h03, wr_count[7:0]);
        power_fail <= 1'b0;
        m.start_cond();
        m.write_byte(ADDR_W, a);
        chk("recovery nack", 8'h00, a);
        m.stop_cond();
        m.wait_cyc(REC_T);
        m.start_cond();
        m.write_byte(ADDR_W, a);
        m.write_byte(8'h02, a);
        m.write_byte(8'h99, a);
        chk("resumed ack", 8'h01, a);
        m.stop_cond();
        chk("resumed write", 8'h99, mem[2]);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) begin
            mem[i] = 8'h10 + 8'(i);
        end
        repeat (2) @(posedge ref_clk);
        sc_reset();
        arst_n <= 1'b1;
        // Power fail syncs reset active, so the recovery window follows reset
        m.wait_cyc(REC_T + 8);
        sc_write();
        sc_read();
        sc_foreign();
        sc_power();
        results();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        bad_count++;
        $display("ERROR watchdog expected done seen hang");
        results();
    end
endmodule
`default_nettype wire

// file: dv/two_wire_master_model.sv
// Behavioural two-wire bus master that drives the serial slave port.
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
    input  wire logic ref_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_low
);
    // ------------------------------------------------------------------
    // Idle bus at time zero; SCL stands high between frames
    // ------------------------------------------------------------------
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------------
    // Bit level: SDA moves 4 cycles into SCL low, sampled mid high phase
    // ------------------------------------------------------------------
    task automatic bit_xfer(input logic b, output logic r);
        sda_low <= ~b;
        wait_cyc(4);
        scl <= 1'b1;
        wait_cyc(4);
        r = sda_wire;
        wait_cyc(4);
        scl <= 1'b0;
        wait_cyc(4);
    endtask

    // Works from idle and as a repeated start with SCL low
    task automatic start_cond();
        @(posedge ref_clk);
        sda_low <= 1'b0;
        wait_cyc(4);
        scl <= 1'b1;
        wait_cyc(8);
        sda_low <= 1'b1;
        wait_cyc(8);
        scl <= 1'b0;
        wait_cyc(4);
    endtask

    task automatic stop_cond();
        sda_low <= 1'b1;
        wait_cyc(4);
        scl <= 1'b1;
        wait_cyc(8);
        sda_low <= 1'b0;
        wait_cyc(8);
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    // Last byte is left unacknowledged so the slave lets go of SDA
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(last, r);
    endtask
endmodule
`default_nettype wire

// file: verilog/line_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module line_sync
    import rtc_serial_pkg::*;
#(
    parameter int WIDTH = SYNC_WIDTH
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t q_reg;
    sync_state_t q_next;

    // First stage feeds only the second stage
    always_comb begin
        q_next        = q_reg;
        q_next.stage1 = async_in;
        q_next.stage2 = q_reg.stage1;
    end

    // Bus lines idle high, so reset to high avoids a false edge at release
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_reg <= '1;
        end else begin
            q_reg <= q_next;
        end
    end

    assign sync_out = q_reg.stage2;

endmodule
`default_nettype wire

// file: verilog/rtc_serial_pkg.sv
// Constants, types and helpers shared by the two-wire serial slave port.
package rtc_serial_pkg;

    // ------------------------------------------------------------------
    // Slave address and location map
    // ------------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR  = 7'h68;
    localparam logic [2:0] LOC_SECONDS = 3'h0;
    localparam logic [2:0] LOC_MINUTES = 3'h1;
    localparam logic [2:0] LOC_HOURS   = 3'h2;
    localparam logic [2:0] LOC_DAY     = 3'h3;
    localparam logic [2:0] LOC_DATE    = 3'h4;
    localparam logic [2:0] LOC_MONTH   = 3'h5;
    localparam logic [2:0] LOC_YEAR    = 3'h6;
    localparam logic [2:0] LOC_CAL     = 3'h7;
    localparam logic [2:0] PTR_RESET   = 3'h0;

    // ------------------------------------------------------------------
    // Byte framing
    // ------------------------------------------------------------------
    localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
    localparam int         RW_BIT         = 0;
    localparam int         MSB_BIT        = 7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 40;
    localparam int REC_TIME_NS  = 1000;
    localparam int REC_CYCLES   = (REC_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int REC_W        = 16;
    localparam int SYNC_WIDTH   = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_RX,
        LINK_RX_ACK,
        LINK_TX,
        LINK_TX_ACK,
        LINK_IGNORE
    } link_state_t;

    typedef enum logic [1:0] {
        KIND_SLAVE,
        KIND_WORD,
        KIND_DATA
    } byte_kind_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] next_ptr(input logic [2:0] p);
        logic [2:0] n;
        n = p + 3'h1;
        if (p == LOC_CAL) begin
            n = LOC_SECONDS;
        end
        return n;
    endfunction

endpackage

// file: verilog/rtc_serial_slave_port.sv
// Two-wire serial slave port of the real-time clock: framing, pointer, freeze.
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_slave_port
    import rtc_serial_pkg::*;
#(
    parameter int REC_COUNT = REC_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       power_fail,
    output logic [2:0]      rd_addr,
    input  wire logic [7:0] rd_data,
    output logic            wr_en,
    output logic [2:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic            copy_hold
);

    // ------------------------------------------------------------------
    // Synchronised pins
    // ------------------------------------------------------------------
    logic [SYNC_WIDTH-1:0] pins_s;
    logic                  scl_s;
    logic                  sda_s;
    logic                  pf_s;

    line_sync #(
        .WIDTH    (SYNC_WIDTH)
    ) u_sync (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .async_in ({power_fail, sda_in, scl_in}),
        .sync_out (pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign pf_s  = pins_s[2];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        link_state_t      state;
        byte_kind_t       kind;
        logic             rw;
        logic [3:0]       bitcnt;
        logic [7:0]       shift;
        logic [2:0]       ptr;
        logic             mack;
        logic             selected;
        logic             sda_oe;
        logic             sda_out;
        logic             hold;
        logic             wr_en;
        logic [2:0]       wr_addr;
        logic [7:0]       wr_data;
        logic [REC_W-1:0] rec_cnt;
        logic             scl_prev;
        logic             sda_prev;
    } port_state_t;

    localparam logic [REC_W-1:0] REC_LOAD = REC_W'(REC_COUNT);

    port_state_t q_reg;
    port_state_t q_next;

    // ------------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic blocked;

    assign scl_rise = scl_s && !q_reg.scl_prev;
    assign scl_fall = !scl_s && q_reg.scl_prev;
    // A data change while SCL is high is a bus condition, not data
    assign start_ev = scl_s && q_reg.scl_prev && q_reg.sda_prev && !sda_s;
    assign stop_ev  = scl_s && q_reg.scl_prev && !q_reg.sda_prev && sda_s;
    assign blocked  = pf_s || (q_reg.rec_cnt != '0);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        q_next          = q_reg;
        q_next.scl_prev = scl_s;
        q_next.sda_prev = sda_s;
        q_next.wr_en    = 1'b0;
        q_next.sda_out  = 1'b0;
        if (pf_s) begin
            // Abort and hold the pointer cleared for as long as supply is low
            q_next.state    = LINK_IDLE;
            q_next.ptr      = PTR_RESET;
            q_next.sda_oe   = 1'b0;
            q_next.selected = 1'b0;
            q_next.rec_cnt  = REC_LOAD;
        end else if (q_reg.rec_cnt != '0) begin
            // Bus input still ignored while the recovery count runs out
            q_next.rec_cnt  = q_reg.rec_cnt - REC_W'(1);
            q_next.state    = LINK_IDLE;
            q_next.sda_oe   = 1'b0;
            q_next.selected = 1'b0;
        end else if (start_ev) begin
            // Repeated START keeps the pointer, so a read resumes there
            q_next.state    = LINK_RX;
            q_next.kind     = KIND_SLAVE;
            q_next.bitcnt   = '0;
            q_next.sda_oe   = 1'b0;
            q_next.selected = 1'b0;
        end else if (stop_ev) begin
            q_next.state    = LINK_IDLE;
            q_next.sda_oe   = 1'b0;
            q_next.selected = 1'b0;
        end else begin
            unique case (q_reg.state)
                LINK_IDLE, LINK_IGNORE: begin
                    q_next.sda_oe = 1'b0;
                end
                LINK_RX: begin
                    if (scl_rise) begin
                        q_next.shift  = {q_reg.shift[6:0], sda_s};
                        q_next.bitcnt = q_reg.bitcnt + 4'h1;
                    end else if (scl_fall && q_reg.bitcnt == BIT_COUNT_FULL) begin
                        unique case (q_reg.kind)
                            KIND_SLAVE: begin
                                if (q_reg.shift[7:1] == SLAVE_ADDR) begin
                                    q_next.rw       = q_reg.shift[RW_BIT];
                                    q_next.selected = 1'b1;
                                    q_next.sda_oe   = 1'b1;
                                    q_next.state    = LINK_RX_ACK;
                                end else begin
                                    q_next.sda_oe = 1'b0;
                                    q_next.state  = LINK_IGNORE;
                                end
                            end
                            KIND_WORD: begin
                                q_next.ptr    = q_reg.shift[2:0];
                                q_next.sda_oe = 1'b1;
                                q_next.state  = LINK_RX_ACK;
                            end
                            default: begin
                                q_next.wr_en   = 1'b1;
                                q_next.wr_addr = q_reg.ptr;
                                q_next.wr_data = q_reg.shift;
                                q_next.sda_oe  = 1'b1;
                                q_next.state   = LINK_RX_ACK;
                            end
                        endcase
                    end
                end
                LINK_RX_ACK: begin
                    if (scl_rise && q_reg.kind == KIND_DATA) begin
                        q_next.ptr = next_ptr(q_reg.ptr);
                    end else if (scl_fall) begin
                        q_next.bitcnt = '0;
                        if (q_reg.kind == KIND_SLAVE && q_reg.rw) begin
                            // Drive the first bit once SCL is low again
                            q_next.state  = LINK_TX;
                            q_next.shift  = rd_data;
                            q_next.sda_oe = !rd_data[MSB_BIT];
                        end else begin
                            q_next.state  = LINK_RX;
                            q_next.sda_oe = 1'b0;
                            q_next.kind   = (q_reg.kind == KIND_SLAVE) ? KIND_WORD : KIND_DATA;
                        end
                    end
                end
                LINK_TX: begin
                    if (scl_fall) begin
                        q_next.bitcnt = q_reg.bitcnt + 4'h1;
                        if (q_reg.bitcnt + 4'h1 == BIT_COUNT_FULL) begin
                            q_next.sda_oe = 1'b0;
                            q_next.state  = LINK_TX_ACK;
                        end else begin
                            q_next.shift  = {q_reg.shift[6:0], 1'b0};
                            q_next.sda_oe = !q_reg.shift[6];
                        end
                    end
                end
                LINK_TX_ACK: begin
                    if (scl_rise) begin
                        q_next.mack = !sda_s;
                        q_next.ptr  = next_ptr(q_reg.ptr);
                    end else if (scl_fall) begin
                        q_next.bitcnt = '0;
                        if (q_reg.mack) begin
                            q_next.state  = LINK_TX;
                            q_next.shift  = rd_data;
                            q_next.sda_oe = !rd_data[MSB_BIT];
                        end else begin
                            // Line left released so the master can stop
                            q_next.state  = LINK_IGNORE;
                            q_next.sda_oe = 1'b0;
                        end
                    end
                end
                default: begin
                    q_next.state  = LINK_IDLE;
                    q_next.sda_oe = 1'b0;
                end
            endcase
        end
        // Freeze lifts at STOP or once the pointer reaches calibration
        q_next.hold = q_next.selected && (q_next.ptr != LOC_CAL);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_reg          <= '0;
            q_reg.scl_prev <= 1'b1;
            q_reg.sda_prev <= 1'b1;
        end else begin
            q_reg <= q_next;
        end
    end

    assign sda_out   = q_reg.sda_out;
    assign sda_oe    = q_reg.sda_oe;
    assign rd_addr   = q_reg.ptr;
    assign wr_en     = q_reg.wr_en;
    assign wr_addr   = q_reg.wr_addr;
    assign wr_data   = q_reg.wr_data;
    assign copy_hold = q_reg.hold;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    a_pf_clears_ptr: assert property ($rose(pf_s) |=>
        (q_reg.ptr == PTR_RESET) && !q_reg.hold)
        else $error("pointer not cleared on power fail");

    a_pf_blocks_bus: assert property (blocked |=> !q_reg.sda_oe && !q_reg.wr_en)
        else $error("bus active while blocked");

    a_rec_interval: assert property ($fell(pf_s) |-> q_reg.rec_cnt == REC_LOAD)
        else $error("recovery count not loaded");

    a_start_enters_rx: assert property (start_ev && !blocked |=>
        q_reg.state == LINK_RX && q_reg.bitcnt == 4'h0 && q_reg.kind == KIND_SLAVE)
        else $error("start not taken");

    a_stop_releases: assert property (stop_ev && !blocked && !start_ev |=>
        q_reg.state == LINK_IDLE && !q_reg.sda_oe && !q_reg.hold)
        else $error("stop did not end transfer");

    a_foreign_addr: assert property (q_reg.state == LINK_RX && scl_fall && !blocked
        && !start_ev && !stop_ev && q_reg.bitcnt == BIT_COUNT_FULL
        && q_reg.kind == KIND_SLAVE && q_reg.shift[7:1] != SLAVE_ADDR
        |=> q_reg.state == LINK_IGNORE && !q_reg.sda_oe)
        else $error("foreign address acknowledged");

    a_ack_driven: assert property (q_reg.state == LINK_RX && scl_fall && !blocked
        && !start_ev && !stop_ev && q_reg.bitcnt == BIT_COUNT_FULL
        && q_reg.kind != KIND_SLAVE |=> q_reg.sda_oe && q_reg.state == LINK_RX_ACK)
        else $error("byte not acknowledged");

    a_sda_scl_low: assert property ($changed(q_reg.sda_oe) && !$past(blocked)
        && !$past(start_ev) && !$past(stop_ev) |-> !$past(scl_s))
        else $error("sda changed while scl high");

    a_tx_ptr_step: assert property (q_reg.state == LINK_TX_ACK && scl_rise && !blocked
        && !start_ev && !stop_ev |=> q_reg.ptr == next_ptr($past(q_reg.ptr)))
        else $error("pointer did not step on ack clock");

    a_ptr_wrap: assert property (q_reg.ptr == LOC_CAL && q_reg.state == LINK_TX_ACK && scl_rise
        && !blocked && !start_ev && !stop_ev |=> q_reg.ptr == LOC_SECONDS)
        else $error("pointer did not wrap");

    a_hold_clock_loc: assert property (q_reg.state inside {LINK_RX_ACK, LINK_TX, LINK_TX_ACK}
        && q_reg.ptr != LOC_CAL |-> q_reg.hold)
        else $error("user copy not frozen");

    a_nack_release: assert property (q_reg.state == LINK_TX_ACK && !q_reg.mack && scl_fall
        && !blocked && !start_ev && !stop_ev |=> !q_reg.sda_oe ##1 !q_reg.sda_oe)
        else $error("sda held after master nack");

endmodule
`default_nettype wire
